/* rtl/rfr_evt_split.sv */
// Event capture stage that splits critical events into reset and alternate paths
`timescale 1ns/100ps
`default_nettype none
module rfr_evt_split (
    input  wire logic                      clk,
    input  wire logic                      rstn,
    input  wire logic [rfr_pkg::EVT_N-1:0] crit_evt,
    input  wire logic [rfr_pkg::EVT_N-1:0] reset_disable,
    input  wire logic [rfr_pkg::EVT_N-1:0] alt_sel,
    output logic      [rfr_pkg::EVT_N-1:0] evt_q,
    output logic                           rst_hit,
    output logic                           safe_hit,
    output logic                           irq_hit
);
    import rfr_pkg::*;

    logic [EVT_N-1:0] evt_r;     // Captured events
    logic [EVT_N-1:0] evt_nxt;   // Next captured events

    // Capture next value
    always_comb begin
        evt_nxt = crit_evt;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            evt_r <= EVT_RESET_VAL;
        end else begin
            evt_r <= evt_nxt;
        end
    end

    // Same registered copy goes to the collector, untouched by the enables
    assign evt_q = evt_r;

    // reset only when disable bit clear
    assign rst_hit  = |(evt_r & ~reset_disable);
    assign safe_hit = |(evt_r & reset_disable & alt_sel);
    assign irq_hit  = |(evt_r & reset_disable & ~alt_sel);

endmodule : rfr_evt_split
`default_nettype wire

/* rtl/rfr_pkg.sv */
// Shared constants and state encoding for the redundant fault reset generator
package rfr_pkg;

    // Number of critical event lines
    localparam int EVT_N = 8;

    // Requested state codes that start a software reset
    localparam logic [3:0] TGT_FUNC_RESET = 4'h0;
    localparam logic [3:0] TGT_DEST_RESET = 4'hF;

    // Value of event registers after reset
    localparam logic [7:0] EVT_RESET_VAL = 8'h00;

    // Clock period and reset pulse hold time (least time, rounded up)
    localparam int CLK_PERIOD_NS = 50;
    localparam int RST_HOLD_NS   = 1000;
    localparam int RST_CYCLES_I  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] RST_CYCLES  = 8'(RST_CYCLES_I);
    localparam logic [7:0] CNT_RESET   = 8'h00;
    localparam logic [7:0] CNT_ONE     = 8'h01;

    // Generator state, one-hot
    typedef enum logic [3:0] {
        RFR_IDLE = 4'h1,
        RFR_FUNC = 4'h2,
        RFR_DEST = 4'h4,
        RFR_SAFE = 4'h8
    } rfr_state_e;

endpackage : rfr_pkg

/* rtl/rfr_reset_gen.sv */
// Redundant fault reset generator: event capture, reset sequencing and safe entry
`timescale 1ns/100ps
`default_nettype none
module rfr_reset_gen (
    input  wire logic                      clk,
    input  wire logic                      rstn,
    input  wire logic [rfr_pkg::EVT_N-1:0] crit_evt,
    input  wire logic                      fc_reset_req,
    input  wire logic [rfr_pkg::EVT_N-1:0] event_reset_disable,
    input  wire logic [rfr_pkg::EVT_N-1:0] event_alt_sel,
    input  wire logic                      mode_ctl_wr,
    input  wire logic [3:0]                mode_ctl_target,
    output logic      [rfr_pkg::EVT_N-1:0] evt_to_fc,
    output logic      [3:0]                rgm_state,
    output logic                           func_reset,
    output logic                           dest_reset,
    output logic                           safe_mode,
    output logic                           alt_irq_req
);
    import rfr_pkg::*;

    // Event split outputs
    logic       rst_hit;       // Reset-enabled event present
    logic       safe_hit;      // Excluded event asking for safe entry
    logic       irq_hit;       // Excluded event asking for interrupt

    // Registered request sources
    logic       fc_req_r;      // Collector request, registered
    logic       fc_req_nxt;
    logic       sw_func_r;     // Software functional reset request
    logic       sw_func_nxt;
    logic       sw_dest_r;     // Software destructive reset request
    logic       sw_dest_nxt;
    logic       alt_irq_r;     // Alternate interrupt pulse
    logic       alt_irq_nxt;

    // Sequencer state
    rfr_state_e state_r;
    rfr_state_e state_nxt;
    logic [7:0] cnt_r;         // Cycles spent in a reset state
    logic [7:0] cnt_nxt;

    // Combined requests
    logic       req_func;
    logic       req_dest;
    logic       cnt_done;

    rfr_evt_split u_split (
        .clk           (clk),
        .rstn          (rstn),
        .crit_evt      (crit_evt),
        .reset_disable (event_reset_disable),
        .alt_sel       (event_alt_sel),
        .evt_q         (evt_to_fc),
        .rst_hit       (rst_hit),
        .safe_hit      (safe_hit),
        .irq_hit       (irq_hit)
    );

    // Next values of the request registers
    always_comb begin
        fc_req_nxt  = fc_reset_req;
        sw_func_nxt = mode_ctl_wr && (mode_ctl_target == TGT_FUNC_RESET);
        sw_dest_nxt = mode_ctl_wr && (mode_ctl_target == TGT_DEST_RESET);
        alt_irq_nxt = irq_hit;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            fc_req_r  <= 1'b0;
            sw_func_r <= 1'b0;
            sw_dest_r <= 1'b0;
            alt_irq_r <= 1'b0;
        end else begin
            fc_req_r  <= fc_req_nxt;
            sw_func_r <= sw_func_nxt;
            sw_dest_r <= sw_dest_nxt;
            alt_irq_r <= alt_irq_nxt;
        end
    end

    assign req_func = rst_hit || fc_req_r || sw_func_r;
    assign req_dest = sw_dest_r;
    assign cnt_done = (cnt_r == RST_CYCLES - CNT_ONE);

    // Sequencer next state; destructive beats functional beats safe entry
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = CNT_RESET;
        unique case (state_r)
            RFR_IDLE, RFR_SAFE: begin
                if (req_dest) begin
                    state_nxt = RFR_DEST;
                end else if (req_func) begin
                    state_nxt = RFR_FUNC;
                end else if (safe_hit) begin
                    state_nxt = RFR_SAFE;
                end
            end
            RFR_FUNC: begin
                // Escalate without waiting out the pulse
                if (req_dest) begin
                    state_nxt = RFR_DEST;
                end else if (cnt_done) begin
                    state_nxt = RFR_IDLE;
                end else begin
                    cnt_nxt = cnt_r + CNT_ONE;
                end
            end
            RFR_DEST: begin
                // Pending requests are seen again from idle
                // Limitation: a one-cycle strobe landing in any cycle of this pulse is dropped
                if (cnt_done) begin
                    state_nxt = RFR_IDLE;
                end else begin
                    cnt_nxt = cnt_r + CNT_ONE;
                end
            end
            default: begin
                // Corrupt code falls into a destructive reset
                state_nxt = RFR_DEST;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r <= RFR_IDLE;
            cnt_r   <= CNT_RESET;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // state presented continuously
    // Reset and mode outputs decode the state register and alt_irq_req is registered, so no request glitch leaks out
    // A destructive reset counts as a functional one too
    assign rgm_state   = state_r;
    assign func_reset  = (state_r == RFR_FUNC) || (state_r == RFR_DEST);
    assign dest_reset  = (state_r == RFR_DEST);
    assign safe_mode   = (state_r == RFR_SAFE);
    assign alt_irq_req = alt_irq_r;

    // Checks next to the logic they guard
    AST_FWD_PATH: assert property (@(posedge clk) disable iff (!rstn)
        $past(rstn) |-> (evt_to_fc == $past(crit_evt)))
        else $error("collector copy of events wrong");

    AST_STATE_OUT: assert property (@(posedge clk) disable iff (!rstn)
        $onehot(rgm_state)
        && (func_reset == ((rgm_state == RFR_FUNC) || (rgm_state == RFR_DEST))))
        else $error("state output disagrees with reset");

    // Two cycles from idle, three when caught leaving a pulse
    AST_FC_REQ: assert property (@(posedge clk) disable iff (!rstn)
        fc_reset_req |-> ##[2:3] func_reset)
        else $error("collector request not honoured");

    // Last pulse cycle drops to idle first, so it is left out
    AST_EVT_RESET: assert property (@(posedge clk) disable iff (!rstn)
        rst_hit && !cnt_done |=> func_reset)
        else $error("enabled event gave no reset");

    AST_EVT_MASKED: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == RFR_IDLE) && !(|(evt_to_fc & ~event_reset_disable))
        && !fc_req_r && !sw_func_r && !sw_dest_r
        |=> !func_reset)
        else $error("reset started with no enabled source");

    AST_ALT_IRQ: assert property (@(posedge clk) disable iff (!rstn)
        (|($past(crit_evt) & event_reset_disable & ~event_alt_sel)) && $past(rstn)
        |=> alt_irq_req)
        else $error("alternate interrupt missing");

    AST_SW_FUNC: assert property (@(posedge clk) disable iff (!rstn)
        (mode_ctl_wr && mode_ctl_target == 4'h0) |-> ##[2:3] func_reset)
        else $error("software functional reset missing");

    AST_SW_DEST: assert property (@(posedge clk) disable iff (!rstn)
        (mode_ctl_wr && mode_ctl_target == 4'hF) |-> ##[2:3] dest_reset)
        else $error("software destructive reset missing");

    AST_DEST_PREEMPT: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == RFR_FUNC) && sw_dest_r |=> dest_reset)
        else $error("destructive request did not preempt");

    // safe left only by a reset
    AST_SAFE_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        (state_r == RFR_SAFE) && !req_func && !req_dest
        |=> safe_mode)
        else $error("safe state left without reset request");

    AST_SHARED: assert property (@(posedge clk) disable iff (!rstn)
        (safe_hit && !req_func && !req_dest && state_r == RFR_IDLE)
        |=> (safe_mode && !func_reset))
        else $error("safe entry not through sequencer");

    AST_REG_SRC: assert property (@(posedge clk) disable iff (!rstn)
        $rose(func_reset) |-> $past(fc_req_r || rst_hit || sw_func_r || sw_dest_r))
        else $error("reset without registered source");

endmodule : rfr_reset_gen
`default_nettype wire

/* verif/rfr_fc_model.sv */
// Behavioural fault collector model facing the reset generator
`timescale 1ns/100ps
`default_nettype none
module rfr_fc_model (
    input  wire logic                      clk,
    input  wire logic                      rstn,
    input  wire logic [rfr_pkg::EVT_N-1:0] evt_to_fc,
    input  wire logic [3:0]                rgm_state,
    input  wire logic                      react_en,
    output logic                           fc_reset_req
);
    import rfr_pkg::*;

    logic req_r;   // Request register
    logic req_nxt; // Next request value

    // Next request: raised on any forwarded event while react_en is set in idle, dropped once the state leaves idle
    always_comb begin
        req_nxt = req_r;
        if (rgm_state != RFR_IDLE) begin
            req_nxt = 1'h0;
        end else if (react_en && (|evt_to_fc)) begin
            req_nxt = 1'h1;
        end
    end

    // Register only
    always_ff @(posedge clk) begin
        if (!rstn) begin
            req_r <= 1'h0;
        end else begin
            req_r <= req_nxt;
        end
    end

    assign fc_reset_req = req_r;
endmodule : rfr_fc_model
`default_nettype wire

/* verif/rfr_reset_gen_bench.sv */
// Self-checking bench for the redundant fault reset generator
`timescale 1ns/100ps
`default_nettype none
module rfr_reset_gen_bench;
    import rfr_pkg::*;
    logic       clk = 1'h0;
    logic       rstn = 1'h0;
    logic [7:0] crit_evt = 8'h00, dis = 8'h00, alt = 8'h00, evt_to_fc;
    logic       wr = 1'h0, react_en = 1'h0, fc_req;
    logic [3:0] tgt = 4'h0, st;
    logic       func_reset, dest_reset, safe_mode, alt_irq;
    int         fails = 0, samples_checked = 0;

    rfr_reset_gen u_rfr_reset_gen (.clk(clk), .rstn(rstn), .crit_evt(crit_evt),
        .fc_reset_req(fc_req), .event_reset_disable(dis), .event_alt_sel(alt),
        .mode_ctl_wr(wr), .mode_ctl_target(tgt), .evt_to_fc(evt_to_fc),
        .rgm_state(st), .func_reset(func_reset), .dest_reset(dest_reset),
        .safe_mode(safe_mode), .alt_irq_req(alt_irq));
    rfr_fc_model u_rfr_fc_model (.clk(clk), .rstn(rstn), .evt_to_fc(evt_to_fc),
        .rgm_state(st), .react_en(react_en), .fc_reset_req(fc_req));

    // 50 ns clock
    initial begin
        forever #25 clk = ~clk;
    end

    // Inputs move 1 ns after the edge, after design updates land
    task step;
        @(posedge clk);
        #1;
    endtask : step
    task chk1(input logic a, input logic e);
        samples_checked++;
        if (a !== e) begin
            fails++;
            $display("CHECK FAILED %0t flag", $time);
        end
    endtask : chk1
    task chk8(input logic [7:0] a, input logic [7:0] e);
        samples_checked++;
        if (a !== e) begin
            fails++;
            $display("CHECK FAILED %0t value %h want %h", $time, a, e);
        end
    endtask : chk8
    task final_report;
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // Count reset pulse length, bounded
    task wait_pulse;
        logic [7:0] n;
        n = 8'h00;
        while (func_reset === 1'h1 && n < 8'h28) begin
            n++;
            step();
        end
        chk8(n, RST_CYCLES);
        chk8({4'h0, st}, {4'h0, RFR_IDLE});
        if (n == 8'h28) final_report();
    endtask : wait_pulse
    // Pulse one event line for one cycle
    task pulse_evt(input logic [7:0] e);
        crit_evt = e;
        step();
        crit_evt = 8'h00;
        chk8(evt_to_fc, e);
    endtask : pulse_evt
    task t_event_reset;
        dis = 8'h00;
        pulse_evt(8'h08);
        chk1(func_reset, 1'h0);
        step();
        chk8({4'h0, st}, {4'h0, RFR_FUNC});
        wait_pulse();
    endtask : t_event_reset
    task t_alt_irq;
        dis = 8'hFF;
        alt = 8'h00;
        pulse_evt(8'h20);
        step();
        chk1(alt_irq, 1'h1);
        chk1(func_reset, 1'h0);
        step();
        chk1(alt_irq, 1'h0);
    endtask : t_alt_irq
    // Software write of requested state
    task t_sw(input logic [3:0] code, input logic d);
        tgt = code;
        wr = 1'h1;
        step();
        wr = 1'h0;
        step();
        chk1(func_reset, 1'h1);
        chk1(dest_reset, d);
        chk1(safe_mode, 1'h0);
        wait_pulse();
    endtask : t_sw
    task t_safe;
        dis = 8'hFF;
        alt = 8'hFF;
        pulse_evt(8'h01);
        step();
        step();
        chk8({4'h0, st}, {4'h0, RFR_SAFE});
        t_sw(TGT_FUNC_RESET, 1'h0);
    endtask : t_safe
    task t_sw_other;
        tgt = 4'h5;
        wr = 1'h1;
        step();
        wr = 1'h0;
        step();
        step();
        chk8({4'h0, st}, {4'h0, RFR_IDLE});
    endtask : t_sw_other
    // Destructive write in mid functional pulse
    task t_preempt;
        tgt = TGT_FUNC_RESET;
        wr = 1'h1;
        step();
        wr = 1'h0;
        repeat (5) step();
        chk1(dest_reset, 1'h0);
        tgt = TGT_DEST_RESET;
        wr = 1'h1;
        step();
        wr = 1'h0;
        step();
        chk1(dest_reset, 1'h1);
        wait_pulse();
    endtask : t_preempt
    task t_collector;
        int k;
        dis = 8'hFF;
        alt = 8'h00;
        react_en = 1'h1;
        pulse_evt(8'h02);
        for (k = 0; k < 8 && func_reset !== 1'h1; k++) step();
        react_en = 1'h0;
        chk1(func_reset, 1'h1);
        if (func_reset !== 1'h1) final_report();
        wait_pulse();
    endtask : t_collector

    // Main sequence
    initial begin
        repeat (4) step();
        rstn = 1'h1;
        step();
        chk8({4'h0, st}, {4'h0, RFR_IDLE});
        chk1(func_reset | dest_reset | safe_mode | alt_irq, 1'h0);
        t_event_reset();
        t_alt_irq();
        t_safe();
        t_sw(TGT_DEST_RESET, 1'h1);
        t_sw_other();
        t_preempt();
        t_collector();
        final_report();
    end
endmodule : rfr_reset_gen_bench
`default_nettype wire
